// ===== sres_map_cfg.svh
// Address map, field positions and codes of the sensor result registers.
// Assumes 16-bit register addresses as seen by the external bus master.
`ifndef SRES_MAP_CFG_SVH
`define SRES_MAP_CFG_SVH

// Block base addresses and the span that this block answers.
`define SRES_WIDE_BASE    16'h00C8
`define SRES_WIDE_FIRST   16'h00D7
`define SRES_WIDE_LAST    16'h00DF
`define SRES_SETUP_ADDR   16'h0191
`define SRES_NARROW_BASE  16'h09C4
`define SRES_NARROW_LAST  16'h09D4

// Word offsets inside the 32-bit result block.
`define SRES_W_VAL7_LO    5'h0F
`define SRES_W_VAL7_HI    5'h10
`define SRES_W_RATE_LO    5'h11
`define SRES_W_RATE_HI    5'h12
`define SRES_W_SEC_LO     5'h13
`define SRES_W_SEC_HI     5'h14
`define SRES_W_USEC_LO    5'h15
`define SRES_W_USEC_HI    5'h16
`define SRES_W_SPARE      5'h17

// Word offsets inside the 16-bit result block.
`define SRES_N_STATUS     5'h00
`define SRES_N_QUALITY    5'h01
`define SRES_N_OUTPUTS    5'h02
`define SRES_N_VAL_FIRST  5'h03
`define SRES_N_VAL_LAST   5'h09
`define SRES_N_RATE       5'h0A
`define SRES_N_SEC_LO     5'h0B
`define SRES_N_SEC_HI     5'h0C
`define SRES_N_USEC_LO    5'h0D
`define SRES_N_USEC_HI    5'h0E
`define SRES_N_SPARE_A    5'h0F
`define SRES_N_SPARE_B    5'h10

// Status word and output byte bit positions.
`define SRES_ST_PARAM     0
`define SRES_ST_SYNC      1
`define SRES_ST_VALID     2
`define SRES_ST_ALARM     3
`define SRES_OUT_BIN1     0
`define SRES_OUT_BIN2     1

// Signal quality codes.
`define SRES_Q_GOOD       2'h0
`define SRES_Q_WEAK       2'h1
`define SRES_Q_NONE       2'h2

// Answer codes of the access port.
`define SRES_EXC_OK       8'h00
`define SRES_EXC_FUNC     8'h01
`define SRES_EXC_ADDR     8'h02

// Reset values.
`define SRES_ZERO16       16'h0000
`define SRES_ZERO32       32'h0000_0000

`endif

// ===== sres_pkg.sv
// Types shared by the sensor result register map.
// Constants live in sres_map_cfg.svh.
package sres_pkg;

  typedef enum logic [1:0] {
    SRES_RGN_NONE,
    SRES_RGN_WIDE,
    SRES_RGN_SETUP,
    SRES_RGN_NARROW
  } sres_region_e;

  typedef enum logic {
    SRES_IDLE,
    SRES_LOOKUP
  } sres_state_e;

  typedef logic [15:0] sres_word_t;

endpackage

// ===== sres_decode.sv
// Address decoder of the sensor result register map.
// Assumes a 16-bit register address; purely combinational.
`timescale 1ns/10ps
`include "sres_map_cfg.svh"

module sres_decode (
  // Register address
  input  wire logic [15:0]          addr_i,
  // Decoded region and word offset
  output sres_pkg::sres_region_e    region_o,
  output logic [4:0]                offset_o
);
  import sres_pkg::*;

  logic [15:0] wide_off;
  logic [15:0] narrow_off;

  assign wide_off   = addr_i - `SRES_WIDE_BASE;
  assign narrow_off = addr_i - `SRES_NARROW_BASE;

  // Only the tail of the 32-bit block is served here; its head is not
  // part of this block and answers as an unknown address.
  always_comb begin
    region_o = SRES_RGN_NONE;
    offset_o = 5'h00;
    if (addr_i >= `SRES_WIDE_FIRST && addr_i <= `SRES_WIDE_LAST) begin
      region_o = SRES_RGN_WIDE;
      offset_o = wide_off[4:0];
    end else if (addr_i == `SRES_SETUP_ADDR) begin
      region_o = SRES_RGN_SETUP;
    end else if (addr_i >= `SRES_NARROW_BASE &&
                 addr_i <= `SRES_NARROW_LAST) begin
      region_o = SRES_RGN_NARROW;
      offset_o = narrow_off[4:0];
    end
  end

endmodule // sres_decode

// ===== sres_regmap.sv
// Read-only result register map of a profile sensor.
// Assumes the measurement core runs on core_clk_i and offers a coherent
// set of results together with a one-cycle load strobe.
`timescale 1ns/10ps
`include "sres_map_cfg.svh"

// Function
// - Status word: mode, sync, valid, alarm bits.
// - Quality reads 0 good, 1 weak, 2 none.
// - Output byte mirrors binary outputs one, two.
// - Seven values, signed, times 100, offsets 3-9.
// - Rate in tenths of hertz at offset 10.
// - Seconds stamp, low at 11, high 12.
// - Microseconds stamp at 13, 14; spares 15, 16.
// - Wide block value seven float at 15, 16.
// - Wide rate, stamps at 17-22, 23 reserved.
module sres_regmap #(
  parameter int NUM_VALUES = 7
) (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  // Register access port
  input  wire logic                       acc_req_i,
  input  wire logic                       acc_write_i,
  input  wire logic [15:0]                acc_addr_i,
  output logic                            acc_busy_o,
  output logic                            acc_ack_o,
  output sres_pkg::sres_word_t            acc_rdata_o,
  output logic                            acc_err_o,
  output logic [7:0]                      acc_exc_o,
  // Result capture control
  input  wire logic                       res_load_i,
  input  wire logic                       res_hold_i,
  output logic                            res_pending_o,
  // Result status from the measurement core
  input  wire logic                       res_param_mode_i,
  input  wire logic                       res_time_sync_i,
  input  wire logic                       res_valid_i,
  input  wire logic                       res_alarm_i,
  input  wire logic [1:0]                 res_quality_i,
  input  wire logic                       res_bin_out1_i,
  input  wire logic                       res_bin_out2_i,
  // Result values from the measurement core
  input  wire logic [NUM_VALUES-1:0][15:0] res_scaled_i,
  input  wire logic [31:0]                res_value7_float_i,
  input  wire logic [31:0]                res_rate_float_i,
  input  wire logic [15:0]                res_rate_tenths_i,
  input  wire logic [31:0]                res_stamp_sec_i,
  input  wire logic [31:0]                res_stamp_usec_i,
  input  wire logic [7:0]                 res_setup_num_i
);
  import sres_pkg::*;

  generate
    if (NUM_VALUES < 1 || NUM_VALUES > 7) begin : g_bad_num
      $error("NUM_VALUES must lie between 1 and 7");
    end
  endgenerate

  // Snapshot of the latest results.
  logic                          st_param_reg;
  logic                          st_sync_reg;
  logic                          st_valid_reg;
  logic                          st_alarm_reg;
  logic [1:0]                    quality_reg;
  logic                          bin1_reg;
  logic                          bin2_reg;
  logic [NUM_VALUES-1:0][15:0]   scaled_reg;
  logic [31:0]                   val7_float_reg;
  logic [31:0]                   rate_float_reg;
  logic [15:0]                   rate_tenths_reg;
  logic [31:0]                   sec_reg;
  logic [31:0]                   usec_reg;
  logic [7:0]                    setup_reg;
  logic                          pending_reg;

  // Access port state.
  sres_state_e                   state_reg;
  logic [15:0]                   addr_reg;
  logic                          write_reg;
  logic                          busy_reg;
  logic                          ack_reg;
  logic                          err_reg;
  logic [7:0]                    exc_reg;
  sres_word_t                    rdata_reg;

  // Decoder results and read multiplexer.
  sres_region_e                  region;
  logic [4:0]                    offset;
  sres_word_t                    rdata_next;
  logic [7:0]                    exc_next;
  logic                          take;
  logic                          capture;
  logic [4:0]                    val_idx;

  // A load that meets the hold is deferred, not dropped, so a master
  // reading several words in one frame never sees a mixed set.
  assign take    = (state_reg == SRES_IDLE) && acc_req_i;
  assign capture = !res_hold_i && (res_load_i || pending_reg);
  assign val_idx = offset - `SRES_N_VAL_FIRST;

  sres_decode u_decode (
    .addr_i   (addr_reg),
    .region_o (region),
    .offset_o (offset)
  );

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      pending_reg <= 1'b0;
    end else if (res_hold_i && res_load_i) begin
      pending_reg <= 1'b1;
    end else if (capture) begin
      pending_reg <= 1'b0;
    end
  end

  // Status flags, quality and outputs.
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_param_reg <= 1'b0;
      st_sync_reg  <= 1'b0;
      st_valid_reg <= 1'b0;
      st_alarm_reg <= 1'b0;
      quality_reg  <= `SRES_Q_NONE;
      bin1_reg     <= 1'b0;
      bin2_reg     <= 1'b0;
    end else if (capture) begin
      st_param_reg <= res_param_mode_i;
      st_sync_reg  <= res_time_sync_i;
      st_valid_reg <= res_valid_i;
      st_alarm_reg <= res_alarm_i;
      // An undefined code from the core is shown as no signal, the
      // safest reading for a master that trusts the value.
      if (res_quality_i == `SRES_Q_GOOD ||
          res_quality_i == `SRES_Q_WEAK) begin
        quality_reg <= res_quality_i;
      end else begin
        quality_reg <= `SRES_Q_NONE;
      end
      bin1_reg     <= res_bin_out1_i;
      bin2_reg     <= res_bin_out2_i;
    end
  end

  // Scaled 16-bit measured values, one register per value.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VALUES; gi++) begin : g_val
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          scaled_reg[gi] <= `SRES_ZERO16;
        end else if (capture) begin
          scaled_reg[gi] <= res_scaled_i[gi];
        end
      end
    end
  endgenerate

  // Wide values, rate and time stamps.
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      val7_float_reg  <= `SRES_ZERO32;
      rate_float_reg  <= `SRES_ZERO32;
      rate_tenths_reg <= `SRES_ZERO16;
      sec_reg         <= `SRES_ZERO32;
      usec_reg        <= `SRES_ZERO32;
    end else if (capture) begin
      val7_float_reg  <= res_value7_float_i;
      rate_float_reg  <= res_rate_float_i;
      rate_tenths_reg <= res_rate_tenths_i;
      sec_reg         <= res_stamp_sec_i;
      usec_reg        <= res_stamp_usec_i;
    end
  end

  // The setup number follows the same snapshot as the results it made.
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      setup_reg <= 8'h00;
    end else if (capture) begin
      setup_reg <= res_setup_num_i;
    end
  end

  // Read multiplexer over the latched address.
  always_comb begin
    rdata_next = `SRES_ZERO16;
    exc_next   = `SRES_EXC_OK;
    case (region)
      SRES_RGN_WIDE: begin
        case (offset)
          `SRES_W_VAL7_LO: rdata_next = val7_float_reg[15:0];
          `SRES_W_VAL7_HI: rdata_next = val7_float_reg[31:16];
          `SRES_W_RATE_LO: rdata_next = rate_float_reg[15:0];
          `SRES_W_RATE_HI: rdata_next = rate_float_reg[31:16];
          `SRES_W_SEC_LO:  rdata_next = sec_reg[15:0];
          `SRES_W_SEC_HI:  rdata_next = sec_reg[31:16];
          `SRES_W_USEC_LO: rdata_next = usec_reg[15:0];
          `SRES_W_USEC_HI: rdata_next = usec_reg[31:16];
          default:         rdata_next = `SRES_ZERO16;
        endcase
      end
      SRES_RGN_SETUP: begin
        rdata_next = {8'h00, setup_reg};
      end
      SRES_RGN_NARROW: begin
        case (offset)
          `SRES_N_STATUS: begin
            rdata_next[`SRES_ST_PARAM] = st_param_reg;
            rdata_next[`SRES_ST_SYNC]  = st_sync_reg;
            rdata_next[`SRES_ST_VALID] = st_valid_reg;
            rdata_next[`SRES_ST_ALARM] = st_alarm_reg;
          end
          `SRES_N_QUALITY: rdata_next = {14'h0000, quality_reg};
          `SRES_N_OUTPUTS: begin
            rdata_next[`SRES_OUT_BIN1] = bin1_reg;
            rdata_next[`SRES_OUT_BIN2] = bin2_reg;
          end
          `SRES_N_RATE:    rdata_next = rate_tenths_reg;
          `SRES_N_SEC_LO:  rdata_next = sec_reg[15:0];
          `SRES_N_SEC_HI:  rdata_next = sec_reg[31:16];
          `SRES_N_USEC_LO: rdata_next = usec_reg[15:0];
          `SRES_N_USEC_HI: rdata_next = usec_reg[31:16];
          `SRES_N_SPARE_A: rdata_next = `SRES_ZERO16;
          `SRES_N_SPARE_B: rdata_next = `SRES_ZERO16;
          default: begin
            // Value slots beyond NUM_VALUES read as zero.
            if (offset >= `SRES_N_VAL_FIRST &&
                offset <= `SRES_N_VAL_LAST &&
                val_idx < 5'(NUM_VALUES)) begin
              rdata_next = scaled_reg[val_idx[2:0]];
            end
          end
        endcase
      end
      default: begin
        exc_next = `SRES_EXC_ADDR;
      end
    endcase
    // A write is refused even at a known address; the snapshot
    // registers have no write path at all.
    if (write_reg && region != SRES_RGN_NONE) begin
      exc_next   = `SRES_EXC_FUNC;
    end
    if (exc_next != `SRES_EXC_OK) begin
      rdata_next = `SRES_ZERO16;
    end
  end

  // Access sequencing: take, look up, answer with a one-cycle ack.
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_reg <= SRES_IDLE;
      addr_reg  <= 16'h0000;
      write_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      case (state_reg)
        SRES_IDLE: begin
          if (take) begin
            addr_reg  <= acc_addr_i;
            write_reg <= acc_write_i;
            busy_reg  <= 1'b1;
            state_reg <= SRES_LOOKUP;
          end
        end
        SRES_LOOKUP: begin
          busy_reg  <= 1'b0;
          state_reg <= SRES_IDLE;
        end
        default: begin
          busy_reg  <= 1'b0;
          state_reg <= SRES_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      exc_reg   <= `SRES_EXC_OK;
      rdata_reg <= `SRES_ZERO16;
    end else if (state_reg == SRES_LOOKUP) begin
      ack_reg   <= 1'b1;
      err_reg   <= (exc_next != `SRES_EXC_OK);
      exc_reg   <= exc_next;
      rdata_reg <= rdata_next;
    end else begin
      ack_reg   <= 1'b0;
    end
  end

  assign acc_busy_o    = busy_reg;
  assign acc_ack_o     = ack_reg;
  assign acc_err_o     = err_reg;
  assign acc_exc_o     = exc_reg;
  assign acc_rdata_o   = rdata_reg;
  assign res_pending_o = pending_reg;

endmodule // sres_regmap

// ===== sres_regmap_asserts.sv
// Checker for the access and capture ports of the result register map.
// Bound to sres_regmap; sees only its ports, one clock domain.
`timescale 1ns/10ps
module sres_regmap_asserts #(
  parameter int NUM_VALUES = 7
) (
  // Clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  // Access port
  input  wire logic                 acc_req_i,
  input  wire logic                 acc_write_i,
  input  wire logic                 acc_busy_o,
  input  wire logic                 acc_ack_o,
  input  wire sres_pkg::sres_word_t acc_rdata_o,
  input  wire logic                 acc_err_o,
  input  wire logic [7:0]           acc_exc_o,
  // Capture control
  input  wire logic                 res_load_i,
  input  wire logic                 res_hold_i,
  input  wire logic                 res_pending_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic take;
  assign take = acc_req_i && !acc_busy_o;

  // The answer register loads at the lookup edge, one edge after the take.
  ack_timing_a: assert property (take |=> acc_busy_o && !acc_ack_o ##1
    acc_ack_o && !acc_busy_o)
    else $error("access answer not two cycles after request");
  ack_pulse_a: assert property (acc_ack_o |=> !acc_ack_o)
    else $error("answer strobe longer than one cycle");
  busy_pulse_a: assert property (acc_busy_o |=> !acc_busy_o)
    else $error("busy longer than one cycle");
  ack_cause_a: assert property (acc_ack_o |-> $past(acc_busy_o))
    else $error("answer without an accepted request");
  write_refuse_a: assert property (take && acc_write_i |-> ##2
    acc_err_o && acc_rdata_o == 16'h0000 && acc_exc_o != 8'h00)
    else $error("write not refused");
  exc_match_a: assert property (acc_ack_o |-> acc_err_o == (acc_exc_o != 8'h00))
    else $error("error flag and answer code disagree");
  answer_hold_a: assert property (!acc_ack_o |-> $stable({acc_rdata_o,
    acc_err_o, acc_exc_o})) else $error("answer changed between strobes");
  pend_set_a: assert property (res_hold_i && (res_load_i || res_pending_o)
    |=> res_pending_o) else $error("deferred load lost");
  pend_clear_a: assert property (res_pending_o && !res_hold_i |=> !res_pending_o)
    else $error("deferred load not applied");
endmodule // sres_regmap_asserts

bind sres_regmap sres_regmap_asserts #(.NUM_VALUES(NUM_VALUES)) u_asserts (
  .core_clk_i, .rstn_i, .acc_req_i, .acc_write_i, .acc_busy_o, .acc_ack_o,
  .acc_rdata_o, .acc_err_o, .acc_exc_o, .res_load_i, .res_hold_i,
  .res_pending_o);

// ===== sres_master_model.sv
// Bus master model issuing single register accesses to the result map.
// Drives on rising edges; one request in flight at a time.
`timescale 1ns/10ps
module sres_master_model (
  // Clock
  input  wire logic        core_clk_i,
  // Answer from the register map
  input  wire logic        acc_busy_i,
  input  wire logic        acc_ack_i,
  input  wire logic [15:0] acc_rdata_i,
  input  wire logic        acc_err_i,
  input  wire logic [7:0]  acc_exc_i,
  // Request to the register map
  output logic             acc_req_o,
  output logic             acc_write_o,
  output logic [15:0]      acc_addr_o
);
  initial begin
    acc_req_o = 1'b0;
    acc_write_o = 1'b0;
    acc_addr_o = 16'h0000;
  end

  task automatic access(input logic w, input logic [15:0] a,
                        output logic [15:0] d, output logic [8:0] r,
                        output logic tmo);
    int n;
    n = 0;
    @(posedge core_clk_i);
    acc_req_o <= 1'b1;
    acc_write_o <= w;
    acc_addr_o <= a;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (acc_busy_i !== 1'b1 && n < 20);
    // Released lines toggle so that a stale address is never mistaken.
    acc_req_o <= 1'b0;
    acc_write_o <= ~w;
    acc_addr_o <= ~a;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (acc_ack_i !== 1'b1 && n < 40);
    d = acc_rdata_i;
    r = {acc_err_i, acc_exc_i};
    tmo = (acc_ack_i !== 1'b1);
  endtask
endmodule // sres_master_model

// ===== sres_regmap_tb_top.sv
// Self-checking bench of the sensor result register map.
// Drives the result inputs directly; accesses go through the master model.
`timescale 1ns/10ps
module sres_regmap_tb_top;
  import sres_pkg::*;
  typedef struct packed {
    logic [3:0]       flg;
    logic [1:0]       q;
    logic [1:0]       b;
    logic [6:0][15:0] sc;
    logic [31:0]      v7, rf, sec, us;
    logic [15:0]      ten;
    logic [7:0]       setup;
  } sres_snap_s;
  logic       core_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ld = 1'b0;
  logic       hold = 1'b0;
  sres_snap_s cur, snap;
  logic       req, wr, busy, ack, err, pend;
  logic [15:0] addr;
  sres_word_t rdata;
  logic [7:0] exc;
  int         error_cnt = 0;
  int         checked = 0;
  int         cyc = 0;

  always #5 core_clk = ~core_clk;

  sres_regmap u_dut (.core_clk_i(core_clk), .rstn_i(rstn), .acc_req_i(req),
    .acc_write_i(wr), .acc_addr_i(addr), .acc_busy_o(busy), .acc_ack_o(ack),
    .acc_rdata_o(rdata), .acc_err_o(err), .acc_exc_o(exc), .res_load_i(ld),
    .res_hold_i(hold), .res_pending_o(pend), .res_param_mode_i(cur.flg[0]),
    .res_time_sync_i(cur.flg[1]), .res_valid_i(cur.flg[2]),
    .res_alarm_i(cur.flg[3]), .res_quality_i(cur.q),
    .res_bin_out1_i(cur.b[0]), .res_bin_out2_i(cur.b[1]),
    .res_scaled_i(cur.sc), .res_value7_float_i(cur.v7),
    .res_rate_float_i(cur.rf), .res_rate_tenths_i(cur.ten),
    .res_stamp_sec_i(cur.sec), .res_stamp_usec_i(cur.us),
    .res_setup_num_i(cur.setup));

  sres_master_model u_mst (.core_clk_i(core_clk), .acc_busy_i(busy),
    .acc_ack_i(ack), .acc_rdata_i(rdata), .acc_err_i(err), .acc_exc_i(exc),
    .acc_req_o(req), .acc_write_o(wr), .acc_addr_o(addr));

  task automatic end_sim();
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  function automatic logic [15:0] exp_w(logic [15:0] a);
    case (a)
      16'h09C4: return {12'h000, snap.flg};
      16'h09C5: return {14'h0000, (snap.q == 2'h3) ? 2'h2 : snap.q};
      16'h09C6: return {14'h0000, snap.b};
      16'h09CE: return snap.ten;
      16'h09CF, 16'h00DB: return snap.sec[15:0];
      16'h09D0, 16'h00DC: return snap.sec[31:16];
      16'h09D1, 16'h00DD: return snap.us[15:0];
      16'h09D2, 16'h00DE: return snap.us[31:16];
      16'h00D7: return snap.v7[15:0];
      16'h00D8: return snap.v7[31:16];
      16'h00D9: return snap.rf[15:0];
      16'h00DA: return snap.rf[31:16];
      16'h0191: return {8'h00, snap.setup};
      default: return (a >= 16'h09C7 && a <= 16'h09CD) ?
                      snap.sc[a - 16'h09C7] : 16'h0000;
    endcase
  endfunction

  task automatic acc(logic w, logic [15:0] a, logic [15:0] e, logic [8:0] r);
    logic [15:0] d;
    logic [8:0]  g;
    logic        t;
    u_mst.access(w, a, d, g, t);
    if (t) begin
      error_cnt++;
      end_sim();
    end
    // A refused access of any kind answers with zero read data.
    chk("rdata", e, d);
    chk("answer", {7'h00, r}, {7'h00, g});
  endtask

  task automatic load();
    @(posedge core_clk);
    ld <= 1'b1;
    @(posedge core_clk);
    ld <= 1'b0;
    if (!hold)
      snap = cur;
  endtask

  task automatic sweep();
    for (int i = 0; i < 17; i++)
      acc(1'b0, 16'h09C4 + 16'(i), exp_w(16'h09C4 + 16'(i)), 9'h000);
    for (int i = 0; i < 9; i++)
      acc(1'b0, 16'h00D7 + 16'(i), exp_w(16'h00D7 + 16'(i)), 9'h000);
    acc(1'b0, 16'h0191, exp_w(16'h0191), 9'h000);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    cur = '0;
    snap = '0;
    snap.q = 2'h2;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    sweep();
    @(posedge core_clk);
    cur <= '{flg: 4'h5, q: 2'h1, b: 2'h1, sc: {16'h8000, 16'h7FFF,
      16'hFF9C, 16'h0064, 16'h0000, 16'hFB2E, 16'h04D2},
      v7: 32'h4048F5C3, rf: 32'h42C80000, sec: 32'h12345678,
      us: 32'h000F423F, ten: 16'h03E8, setup: 8'h03};
    load();
    sweep();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      cur.q <= 2'(i);
      cur.flg <= 4'h1 << i;
      cur.b <= 2'(i);
      load();
      acc(1'b0, 16'h09C4, exp_w(16'h09C4), 9'h000);
      acc(1'b0, 16'h09C5, exp_w(16'h09C5), 9'h000);
      acc(1'b0, 16'h09C6, exp_w(16'h09C6), 9'h000);
    end
    acc(1'b1, 16'h09C7, 16'h0000, 9'h101);
    acc(1'b1, 16'h0191, 16'h0000, 9'h101);
    acc(1'b1, 16'h1234, 16'h0000, 9'h102);
    acc(1'b0, 16'h09C7, exp_w(16'h09C7), 9'h000);
    acc(1'b0, 16'h00C8, 16'h0000, 9'h102);
    acc(1'b0, 16'h00D6, 16'h0000, 9'h102);
    acc(1'b0, 16'h0190, 16'h0000, 9'h102);
    acc(1'b0, 16'h09C3, 16'h0000, 9'h102);
    acc(1'b0, 16'h00E0, 16'h0000, 9'h102);
    acc(1'b0, 16'h09D5, 16'h0000, 9'h102);
    @(posedge core_clk);
    hold <= 1'b1;
    cur.sec <= 32'hCAFE0001;
    cur.sc[0] <= 16'h0001;
    load();
    acc(1'b0, 16'h09CF, exp_w(16'h09CF), 9'h000);
    chk("pending", 16'h0001, {15'h0000, pend});
    hold <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    snap = cur;
    acc(1'b0, 16'h09CF, exp_w(16'h09CF), 9'h000);
    acc(1'b0, 16'h09C7, exp_w(16'h09C7), 9'h000);
    // A reset in mid-run must drop the snapshot back to its reset values.
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    snap = '0;
    snap.q = 2'h2;
    chk("pending", 16'h0000, {15'h0000, pend});
    sweep();
    end_sim();
  end
endmodule // sres_regmap_tb_top
